// file: hw/gpx_port.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// RL1: up to eight pins, each independently input or output
// RL2: bit n of data, direction and option registers maps to pin n
// RL3: direction zero means input; data read returns pin level
// RL4: option bit picks floating or pull-up input, with interrupt
// RL5: data write on input pin only updates the latch
// RL6: software loads data before switching pin to output
// RL7: software avoids bit set/clear read-modify-write on data
// RL8: each interrupt input pin can raise the external request
// RL9: event kind set by separate sensitivity register
// RL10: qualified pin events are ORed into one request
// RL11: request latch hidden, cleared on vector fetch
// RL12: writing the sensitivity register cancels a pending request
// RL13: direction one drives latch; data read returns latch
// RL14: option selects push-pull or open-drain; zero always drives low
// RL15: peripheral alternate function overrides standard I/O
// RL16: outgoing peripheral signal forces output with its own drive mode
// RL17: incoming peripheral signal still readable through data register
// RL18: software sets shared-direction peripheral pins floating input
// RL19: interrupt only in interrupt input config and mask inactive
// RL20: input pin with alternate output reads alternate output value
// RL21: output pin with alternate input feeds latch to peripheral
// RL22: reset clears data, direction and option registers
module gpx_port
   import gpx_pkg::*;
#(
   parameter int PINS = GPX_PINS
) (
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // register port
   input  wire gpx_bus_req_type bus_i,
   output logic [7:0]           rdata_o,
   // pads
   input  wire logic [PINS-1:0] pin_in_i,
   output logic [PINS-1:0]      pin_out_o,
   output logic [PINS-1:0]      pin_oe_o,
   output logic [PINS-1:0]      pin_pull_o,
   // alternate functions
   input  wire logic [PINS-1:0] alt_out_en_i,
   input  wire logic [PINS-1:0] alt_out_i,
   input  wire logic [PINS-1:0] alt_od_i,
   input  wire logic [PINS-1:0] alt_in_en_i,
   output logic [PINS-1:0]      alt_in_o,
   // processor interrupt side
   input  wire logic            irq_mask_i,
   input  wire logic            vec_fetch_i,
   output logic                 irq_req_o
);

   // ***********************************************************
   // state
   // ***********************************************************
   logic [PINS-1:0] data_reg,  data_next;
   logic [PINS-1:0] dir_reg,   dir_next;
   logic [PINS-1:0] opt_reg,   opt_next;
   logic [7:0]      sens_reg,  sens_next;
   logic [PINS-1:0] prev_reg,  prev_next;
   logic            pend_reg,  pend_next;
   logic [7:0]      rdata_reg, rdata_next;
   gpx_pad_type     pad_reg,   pad_next;
   logic [PINS-1:0] alt_reg,   alt_next;
   logic            irq_reg,   irq_next;

   logic [PINS-1:0] irq_cfg;
   logic [PINS-1:0] hit;
   logic [PINS-1:0] read_val;
   logic [1:0]      ev_mode;
   logic            ev_inv;

   // widen a pin vector into the 8-bit register lane, upper bits zero
   function automatic logic [7:0] gpx_widen(input logic [PINS-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      r[PINS-1:0] = v;
      return r;
   endfunction

   // ***********************************************************
   // event detection
   // ***********************************************************
   always_comb begin
      ev_mode = sens_reg[GPX_SENS_MODE_LSB +: 2];                         // RL9
      ev_inv  = sens_reg[GPX_SENS_INV_BIT];
      irq_cfg = ~dir_reg & opt_reg;                                       // RL4 RL19
      for (int n = 0; n < PINS; n++) begin
         logic lv;
         logic pv;
         lv = pin_in_i[n] ^ ev_inv;
         pv = prev_reg[n] ^ ev_inv;
         unique case (ev_mode)
            GPX_EV_FALL_LOW: hit[n] = ~lv;
            GPX_EV_RISE:     hit[n] = lv & ~pv;
            GPX_EV_FALL:     hit[n] = ~lv & pv;
            GPX_EV_BOTH:     hit[n] = lv ^ pv;
         endcase
         hit[n] = hit[n] & irq_cfg[n];                                    // RL8
      end
   end

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      data_next = data_reg;
      dir_next  = dir_reg;
      opt_next  = opt_reg;
      sens_next = sens_reg;
      prev_next = pin_in_i;
      pend_next = pend_reg;
      // read value per pin: latch for outputs, pin or alternate for inputs
      for (int n = 0; n < PINS; n++) begin
         if (dir_reg[n]) begin
            read_val[n] = data_reg[n];                                    // RL13
         end else if (alt_out_en_i[n]) begin
            read_val[n] = alt_out_i[n];                                   // RL20
         end else begin
            read_val[n] = pin_in_i[n];                                    // RL3 RL17
         end
      end
      rdata_next = 8'h00;
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            GPX_OFF_DATA: rdata_next = gpx_widen(read_val);
            GPX_OFF_DIR:  rdata_next = gpx_widen(dir_reg);
            GPX_OFF_OPT:  rdata_next = gpx_widen(opt_reg);
            GPX_OFF_SENS: rdata_next = sens_reg;
         endcase
      end
      // writes: data always goes to the latch only (RL5), pin follows dir
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            GPX_OFF_DATA: data_next = bus_i.wdata[PINS-1:0];              // RL5 RL2
            GPX_OFF_DIR:  dir_next  = bus_i.wdata[PINS-1:0];              // RL1
            GPX_OFF_OPT:  opt_next  = bus_i.wdata[PINS-1:0];
            GPX_OFF_SENS: sens_next = bus_i.wdata;
         endcase
      end
      // request latch: fetch or any sensitivity write clears, new event wins
      if (vec_fetch_i) begin
         pend_next = 1'b0;                                                // RL11
      end
      if (bus_i.wr && bus_i.addr == GPX_OFF_SENS) begin
         pend_next = 1'b0;                                                // RL12
      end
      if (|hit) begin
         pend_next = 1'b1;                                                // RL10
      end
      // the mask gates the request, not the latch, so nothing is lost while masked
      irq_next = pend_next & ~irq_mask_i;                                 // RL19
   end

   // ***********************************************************
   // pad drive
   // ***********************************************************
   always_comb begin
      // upper lanes of the pad bundle stay zero when fewer pins are built
      pad_next = '0;
      for (int n = 0; n < PINS; n++) begin
         logic v;
         logic od;
         logic drv;
         v   = 1'b0;
         od  = 1'b0;
         drv = 1'b0;
         if (alt_out_en_i[n]) begin
            v   = alt_out_i[n];                                           // RL15 RL16
            od  = alt_od_i[n];
            drv = 1'b1;
         end else begin
            v   = data_reg[n];
            od  = ~opt_reg[n];
            drv = dir_reg[n];
         end
         // open drain releases a high rather than driving it
         pad_next.out[n]  = v;
         pad_next.oe[n]   = drv & (~v | ~od);                             // RL14
         pad_next.pull[n] = ~drv & opt_reg[n];                            // RL4
         // peripheral sees the latch when the pin is an output, zero when unused
         alt_next[n] = alt_in_en_i[n] & (dir_reg[n] ? data_reg[n] : pin_in_i[n]); // RL21
      end
   end

   // ***********************************************************
   // registers
   // ***********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_reg  <= GPX_RST_PORT[PINS-1:0];                             // RL22
         dir_reg   <= GPX_RST_PORT[PINS-1:0];
         opt_reg   <= GPX_RST_PORT[PINS-1:0];
         sens_reg  <= GPX_RST_SENS;
         prev_reg  <= '0;
         pend_reg  <= 1'b0;
         rdata_reg <= 8'h00;
         pad_reg   <= '0;
         alt_reg   <= '0;
      end else begin
         data_reg  <= data_next;
         dir_reg   <= dir_next;
         opt_reg   <= opt_next;
         sens_reg  <= sens_next;
         prev_reg  <= prev_next;
         pend_reg  <= pend_next;
         rdata_reg <= rdata_next;
         pad_reg   <= pad_next;
         alt_reg   <= alt_next;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   // request flop kept apart so its reset value sits next to the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end
   assign irq_req_o  = irq_reg;
   assign rdata_o    = rdata_reg;
   assign pin_out_o  = pad_reg.out[PINS-1:0];
   assign pin_oe_o   = pad_reg.oe[PINS-1:0];
   assign pin_pull_o = pad_reg.pull[PINS-1:0];
   assign alt_in_o   = alt_reg;

   // ***********************************************************
   // checks
   // ***********************************************************
   AST_RESET_CLEARS: assert property (@(posedge clk_i) rst_i |=> // RL22
      dir_reg == '0 && opt_reg == '0 && data_reg == '0)
      else $error("port registers not cleared by reset");
   AST_INPUT_UNDRIVEN: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
      (dir_reg == '0 && alt_out_en_i == '0) |=> pin_oe_o == '0)
      else $error("input pin driven");
   AST_READ_LATCH: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
      (bus_i.rd && bus_i.addr == GPX_OFF_DATA && dir_reg == '1)
      |=> rdata_o[PINS-1:0] == $past(data_reg))
      else $error("output read not latch");
   AST_READ_PIN: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
      (bus_i.rd && bus_i.addr == GPX_OFF_DATA && dir_reg == '0 && alt_out_en_i == '0)
      |=> rdata_o[PINS-1:0] == $past(pin_in_i))
      else $error("input read not pin");
   AST_OD_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
      (alt_out_en_i == '0 && dir_reg[0] && !data_reg[0]) |=> pin_oe_o[0] && !pin_out_o[0])
      else $error("zero not driven low");
   AST_SENS_CANCEL: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
      (bus_i.wr && bus_i.addr == GPX_OFF_SENS && hit == '0) |=> !pend_reg)
      else $error("pending not cancelled");
   AST_FETCH_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
      (vec_fetch_i && hit == '0) |=> !pend_reg && !irq_req_o)
      else $error("fetch did not clear request");
   AST_MASK_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
      irq_mask_i |=> !irq_req_o)
      else $error("request while masked");
   AST_EVENT_RAISE: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
      (|hit && !irq_mask_i) |=> pend_reg && irq_req_o)
      else $error("event not raised");
   // register writes land and reads return the addressed register
   AST_WRITE_DATA: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
      (bus_i.wr && bus_i.addr == GPX_OFF_DATA) |=> data_reg == $past(bus_i.wdata[PINS-1:0]))
      else $error("data latch write lost");
   AST_WRITE_DIR: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
      (bus_i.wr && bus_i.addr == GPX_OFF_DIR) |=> dir_reg == $past(bus_i.wdata[PINS-1:0]))
      else $error("direction write lost");
   AST_WRITE_OPT: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
      (bus_i.wr && bus_i.addr == GPX_OFF_OPT) |=> opt_reg == $past(bus_i.wdata[PINS-1:0]))
      else $error("option write lost");
   AST_WRITE_SENS: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      (bus_i.wr && bus_i.addr == GPX_OFF_SENS) |=> sens_reg == $past(bus_i.wdata))
      else $error("sensitivity write lost");
   AST_READ_DIR: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
      (bus_i.rd && bus_i.addr == GPX_OFF_DIR) |=> rdata_o[PINS-1:0] == $past(dir_reg))
      else $error("direction read wrong");
   AST_READ_OPT: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
      (bus_i.rd && bus_i.addr == GPX_OFF_OPT) |=> rdata_o[PINS-1:0] == $past(opt_reg))
      else $error("option read wrong");
   AST_READ_SENS: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      (bus_i.rd && bus_i.addr == GPX_OFF_SENS) |=> rdata_o == $past(sens_reg))
      else $error("sensitivity read wrong");
   AST_READ_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
      !bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data outside read cycle");
   AST_READ_ALT: assert property (@(posedge clk_i) disable iff (rst_i) // RL20
      (bus_i.rd && bus_i.addr == GPX_OFF_DATA && !dir_reg[0] && alt_out_en_i[0])
      |=> rdata_o[0] == $past(alt_out_i[0]))
      else $error("input read not alternate output");
   // standard pad drive and pulls
   AST_PUSH_HIGH: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
      (!alt_out_en_i[0] && dir_reg[0] && data_reg[0] && opt_reg[0])
      |=> pin_oe_o[0] && pin_out_o[0])
      else $error("push-pull one not driven high");
   AST_OD_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
      (!alt_out_en_i[0] && dir_reg[0] && data_reg[0] && !opt_reg[0]) |=> !pin_oe_o[0])
      else $error("open drain one not released");
   AST_OUT_LATCH: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
      (!alt_out_en_i[0] && dir_reg[0]) |=> pin_out_o[0] == $past(data_reg[0]))
      else $error("output not from latch");
   AST_PULL_ON: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
      (!alt_out_en_i[0] && !dir_reg[0] && opt_reg[0]) |=> pin_pull_o[0])
      else $error("pull-up missing");
   AST_PULL_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
      (alt_out_en_i[0] || dir_reg[0] || !opt_reg[0]) |=> !pin_pull_o[0])
      else $error("pull-up outside pull-up input");
   // alternate function override
   AST_ALT_PUSH: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
      (alt_out_en_i[0] && !alt_od_i[0]) |=> pin_oe_o[0] && pin_out_o[0] == $past(alt_out_i[0]))
      else $error("alternate output not driven");
   AST_ALT_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
      (alt_out_en_i[0] && alt_od_i[0] && alt_out_i[0]) |=> !pin_oe_o[0])
      else $error("alternate open drain not released");
   AST_ALT_IN_LATCH: assert property (@(posedge clk_i) disable iff (rst_i) // RL21
      (alt_in_en_i[0] && dir_reg[0]) |=> alt_in_o[0] == $past(data_reg[0]))
      else $error("peripheral input not latch");
   AST_ALT_IN_PIN: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
      (alt_in_en_i[0] && !dir_reg[0]) |=> alt_in_o[0] == $past(pin_in_i[0]))
      else $error("peripheral input not pin");
   AST_ALT_IN_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
      !alt_in_en_i[0] |=> !alt_in_o[0])
      else $error("unused peripheral input active");
   // interrupt qualification and the request latch
   AST_RISE_RAISE: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
      (!dir_reg[0] && opt_reg[0] && !prev_reg[0] && pin_in_i[0] && !irq_mask_i &&
       sens_reg[GPX_SENS_MODE_LSB +: 2] == GPX_EV_RISE && !sens_reg[GPX_SENS_INV_BIT])
      |=> irq_req_o)
      else $error("rising edge missed");
   AST_FALL_RAISE: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      (!dir_reg[0] && opt_reg[0] && prev_reg[0] && !pin_in_i[0] && !irq_mask_i &&
       sens_reg[GPX_SENS_MODE_LSB +: 2] == GPX_EV_FALL && !sens_reg[GPX_SENS_INV_BIT])
      |=> irq_req_o)
      else $error("falling edge missed");
   AST_LEVEL_RAISE: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      (!dir_reg[0] && opt_reg[0] && !pin_in_i[0] && !irq_mask_i &&
       sens_reg[GPX_SENS_MODE_LSB +: 2] == GPX_EV_FALL_LOW && !sens_reg[GPX_SENS_INV_BIT])
      |=> irq_req_o)
      else $error("low level missed");
   AST_INV_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      (!dir_reg[0] && opt_reg[0] && pin_in_i[0] && !irq_mask_i &&
       sens_reg[GPX_SENS_MODE_LSB +: 2] == GPX_EV_FALL_LOW && sens_reg[GPX_SENS_INV_BIT])
      |=> irq_req_o)
      else $error("inverted level missed");
   AST_OR_PINS: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
      (!dir_reg[1] && opt_reg[1] && !pin_in_i[1] &&
       sens_reg[GPX_SENS_MODE_LSB +: 2] == GPX_EV_FALL_LOW && !sens_reg[GPX_SENS_INV_BIT])
      |=> pend_reg)
      else $error("second pin not ored");
   AST_NO_CFG: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
      (opt_reg == '0 && !pend_reg) |=> !pend_reg)
      else $error("request without interrupt input");
   AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
      (pend_reg && !vec_fetch_i && !(bus_i.wr && bus_i.addr == GPX_OFF_SENS)) |=> pend_reg)
      else $error("pending request lost");

endmodule

// file: hw/gpx_pkg.sv
package gpx_pkg;

   // ***********************************************************
   // register map
   // ***********************************************************
   localparam logic [1:0] GPX_OFF_DATA  = 2'h0;
   localparam logic [1:0] GPX_OFF_DIR   = 2'h1;
   localparam logic [1:0] GPX_OFF_OPT   = 2'h2;
   localparam logic [1:0] GPX_OFF_SENS  = 2'h3;
   localparam int         GPX_ADDR_W    = 2;
   localparam int         GPX_PINS      = 8;
   localparam logic [7:0] GPX_RST_PORT  = 8'h00;

   // ***********************************************************
   // sensitivity control field layout
   // ***********************************************************
   localparam int         GPX_SENS_MODE_LSB = 0;
   localparam int         GPX_SENS_INV_BIT  = 2;
   localparam logic [7:0] GPX_RST_SENS      = 8'h00;

   // event modes held in the sensitivity register
   localparam logic [1:0] GPX_EV_FALL_LOW = 2'h0;
   localparam logic [1:0] GPX_EV_RISE     = 2'h1;
   localparam logic [1:0] GPX_EV_FALL     = 2'h2;
   localparam logic [1:0] GPX_EV_BOTH     = 2'h3;

   // register bus request
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } gpx_bus_req_type;

   // pad drive bundle
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull;
   } gpx_pad_type;

endpackage

// file: sim/gpx_pad_model.sv
`timescale 1ns/1ns
// ***********************************
// pad and far-side driver model
// ***********************************
module gpx_pad_model #(
   parameter int PINS = 8
) (
   input  wire logic            clk_i,
   input  wire logic [PINS-1:0] out_i,
   input  wire logic [PINS-1:0] oe_i,
   input  wire logic [PINS-1:0] pull_i,
   input  wire logic [PINS-1:0] ext_en_i,
   input  wire logic [PINS-1:0] ext_val_i,
   output logic [PINS-1:0]      lvl_o
);
   logic [PINS-1:0] last_reg = '0;
   // a pin nobody drives toggles, so a stale level is never read as valid
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (oe_i[i])
            lvl_o[i] = out_i[i];
         else if (ext_en_i[i])
            lvl_o[i] = ext_val_i[i];
         else if (pull_i[i])
            lvl_o[i] = 1'b1;
         else
            lvl_o[i] = ~last_reg[i];
      end
   end
   always_ff @(posedge clk_i) last_reg <= lvl_o;
endmodule

// file: sim/gpx_port_bench.sv
`timescale 1ns/1ns
module gpx_port_bench;
   import gpx_pkg::*;
   logic            clk_i, rst_i, mask, vf, irq;
   gpx_bus_req_type bus;
   logic [7:0]      rdata, pin_in, pout, poe, ppull, aoen, aout, aod, aien, ain, exen, exv;
   int              err_count, total_checks, cyc;
   gpx_port u_gpx_port (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
      .pin_in_i(pin_in), .pin_out_o(pout), .pin_oe_o(poe), .pin_pull_o(ppull),
      .alt_out_en_i(aoen), .alt_out_i(aout), .alt_od_i(aod), .alt_in_en_i(aien),
      .alt_in_o(ain), .irq_mask_i(mask), .vec_fetch_i(vf), .irq_req_o(irq));
   gpx_pad_model u_gpx_pad_model (.clk_i(clk_i), .out_i(pout), .oe_i(poe), .pull_i(ppull),
      .ext_en_i(exen), .ext_val_i(exv), .lvl_o(pin_in));
   // ***********************************
   // helpers
   // ***********************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic ext(input logic [7:0] v);
      @(posedge clk_i);
      exv <= v;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_reset;
      for (int a = 0; a < 4; a++) begin
         rd(a[1:0], 8'h00);
      end
      chk(poe | ppull, 8'h00);
   endtask
   task automatic t_out;
      wr(GPX_OFF_DATA, 8'ha5);
      wr(GPX_OFF_OPT, 8'h0f);
      wr(GPX_OFF_DIR, 8'hff);
      tick(2);
      chk(poe, 8'h5f);
      chk(pout & poe, 8'h05);
      rd(GPX_OFF_DATA, 8'ha5);
      rd(GPX_OFF_OPT, 8'h0f);
   endtask
   task automatic t_in;
      ext(8'h3c);
      wr(GPX_OFF_DIR, 8'h00);
      wr(GPX_OFF_OPT, 8'hf0);
      tick(2);
      chk(ppull, 8'hf0);
      rd(GPX_OFF_DATA, 8'h3c);
      @(posedge clk_i);
      exen <= 8'h0f;
      rd(GPX_OFF_DATA, 8'hfc);
      @(posedge clk_i);
      exen <= 8'hff;
      wr(GPX_OFF_DATA, 8'h00);
      tick(2);
      chk(poe, 8'h00);
      rd(GPX_OFF_DATA, 8'h3c);
      wr(GPX_OFF_DIR, 8'hff);
      tick(2);
      chk(poe | pout, 8'hff);
      chk(pout & poe, 8'h00);
   endtask
   // shared in/out peripheral pins sit as floating inputs
   task automatic t_alt;
      wr(GPX_OFF_DIR, 8'h00);
      wr(GPX_OFF_OPT, 8'h00);
      @(posedge clk_i);
      aoen <= 8'h03;
      aout <= 8'h01;
      aod <= 8'h02;
      tick(3);
      chk(poe & 8'h03, 8'h03);
      chk(pout & 8'h03, 8'h01);
      chk(ain, 8'h3d);
      rd(GPX_OFF_DATA, 8'h3d);
      wr(GPX_OFF_DATA, 8'h5a);
      wr(GPX_OFF_DIR, 8'hff);
      @(posedge clk_i);
      aoen <= 8'h00;
      tick(3);
      chk(ain, 8'h5a);
      @(posedge clk_i);
      aien <= 8'h00;
      tick(2);
      chk(ain, 8'h00);
   endtask
   task automatic t_irq;
      ext(8'hff);
      wr(GPX_OFF_DIR, 8'h00);
      wr(GPX_OFF_OPT, 8'h03);
      for (int m = 0; m < 4; m++) begin
         wr(GPX_OFF_SENS, 8'(m));
         tick(3);
         chk({7'h0, irq}, 8'h00);
         ext(8'hfe);
         tick(3);
         chk({7'h0, irq}, {7'h0, m != 1});
         ext(8'hff);
         tick(3);
         chk({7'h0, irq}, 8'h01);
         @(posedge clk_i);
         mask <= 1'b1;
         tick(3);
         chk({7'h0, irq}, 8'h00);
         @(posedge clk_i);
         mask <= 1'b0;
         tick(3);
         chk({7'h0, irq}, 8'h01);
         @(posedge clk_i);
         vf <= 1'b1;
         @(posedge clk_i);
         vf <= 1'b0;
         tick(3);
         chk({7'h0, irq}, 8'h00);
      end
      wr(GPX_OFF_SENS, {6'h0, GPX_EV_FALL});
      ext(8'hfb);
      tick(3);
      chk({7'h0, irq}, 8'h00);
      ext(8'hf9);
      tick(3);
      chk({7'h0, irq}, 8'h01);
      wr(GPX_OFF_SENS, {6'h0, GPX_EV_FALL});
      tick(3);
      chk({7'h0, irq}, 8'h00);
      wr(GPX_OFF_SENS, 8'h04);
      tick(3);
      chk({7'h0, irq}, 8'h01);
      rd(GPX_OFF_SENS, 8'h04);
      ext(8'hfc);
      @(posedge clk_i);
      vf <= 1'b1;
      @(posedge clk_i);
      vf <= 1'b0;
      tick(3);
      chk({7'h0, irq}, 8'h00);
   endtask
   // ***********************************
   // clock, timeout and main sequence
   // ***********************************
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      rst_i = 1'b1;
      bus = '0;
      {mask, vf} = 2'h0;
      {aoen, aout, aod, aien} = 32'h0000_03ff;
      exen = 8'hff;
      exv = 8'h00;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_out();
      t_in();
      t_alt();
      t_irq();
      finish_test();
   end
endmodule
